/* File: src/scr_defines.vh */
// constants and register map of the serial command relay
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH

`define SCR_OFF_CTRL      8'h00
`define SCR_OFF_CMD       8'h04
`define SCR_OFF_DST       8'h08
`define SCR_OFF_PAYLOAD   8'h0c
`define SCR_OFF_CFG       8'h10
`define SCR_OFF_STATUS    8'h14
`define SCR_OFF_RESP_HDR  8'h18
`define SCR_OFF_RESP_SRC  8'h1c
`define SCR_OFF_RESP_PLD  8'h20

`define SCR_CTRL_GO       0
`define SCR_CTRL_BCAST    1
`define SCR_CTRL_COINC    2
`define SCR_CTRL_ASYNC    3

`define SCR_CR_BIT        15
`define SCR_CFG_RETRY_RST 8'h08
`define SCR_CFG_WAIT_RST  16'h0100
`define SCR_OWN_ADDR_RST  16'h0100

`define SCR_CMD_PING      16'h0001
`define SCR_UNKNOWN_CODE  16'h7f01
`define SCR_DEAD_CODE     16'h7f02
`define SCR_TIMEOUT_CODE  16'h7f03
`define SCR_BUSY_CODE     16'h7f04

`define SCR_NUM_SLOTS     10
`define SCR_SS_IDLE       10'h3ff
`define SCR_SCLK_HALF     4

`endif

/* File: src/scr_spi_shifter.v */
// 32-bit mode-0 serial shifter, msb first, clock made by division
`timescale 1ns/1ns
`include "scr_defines.vh"
module scr_spi_shifter #(
  parameter HALF = `SCR_SCLK_HALF
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        start,
  input  wire [31:0] tx,
  output reg  [31:0] rx,
  output reg         busy,
  output reg         done,
  output reg         sclk,
  output reg         mosi,
  input  wire        miso
);
  localparam [7:0] HALF_M1 = HALF - 1;

  reg [7:0]  cnt_reg;
  reg [4:0]  bit_reg;
  reg [31:0] sh_reg;
  reg        miso_s1_reg;
  reg        miso_s2_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg     <= 8'h00;
      bit_reg     <= 5'h00;
      sh_reg      <= 32'h0000_0000;
      rx          <= 32'h0000_0000;
      busy        <= 1'b0;
      done        <= 1'b0;
      sclk        <= 1'b0;
      mosi        <= 1'b0;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      miso_s1_reg <= miso;
      miso_s2_reg <= miso_s1_reg;
      done        <= 1'b0;
      if (!busy)
      begin
        if (start)
        begin
          sh_reg  <= tx;
          mosi    <= tx[31];
          busy    <= 1'b1;
          cnt_reg <= 8'h00;
          bit_reg <= 5'h00;
        end
      end
      else if (cnt_reg == HALF_M1)
      begin
        cnt_reg <= 8'h00;
        if (!sclk)
          sclk <= 1'b1;
        else
        begin
          // sampled late in the high phase so the two-stage sync has settled
          sclk   <= 1'b0;
          sh_reg <= {sh_reg[30:0], miso_s2_reg};
          bit_reg <= bit_reg + 5'h01;
          if (bit_reg == 5'h1f)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            rx   <= {sh_reg[30:0], miso_s2_reg};
          end
          else
            mosi <= sh_reg[30];
        end
      end
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // scr_spi_shifter

/* File: src/scr_relay.v */
// parent command relay: apb command port, 10-slot serial master, poll and retry
`timescale 1ns/1ns
`include "scr_defines.vh"
module scr_relay #(
  parameter [15:0] OWN_ADDR = `SCR_OWN_ADDR_RST,
  parameter        HALF     = `SCR_SCLK_HALF
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output wire        spi_sclk,
  output wire        spi_mosi,
  input  wire        spi_miso,
  output reg  [9:0]  spi_ss_n,
  output reg         relay_busy
);
  localparam [3:0] ST_IDLE     = 4'h0;
  localparam [3:0] ST_LOCAL    = 4'h1;
  localparam [3:0] ST_WR_HDR   = 4'h2;
  localparam [3:0] ST_WR_PLD   = 4'h3;
  localparam [3:0] ST_WR_ECHO  = 4'h4;
  localparam [3:0] ST_POLL     = 4'h5;
  localparam [3:0] ST_POLL_PLD = 4'h6;
  localparam [3:0] ST_WAIT     = 4'h7;

  // one-hot active-low select for a slot, all high for an invalid slot
  function [9:0] slot_sel_n;
    input [15:0] dst;
    begin
      if (dst < `SCR_NUM_SLOTS)
        slot_sel_n = ~(10'h001 << dst[3:0]);
      else
        slot_sel_n = `SCR_SS_IDLE;
    end
  endfunction

  function is_reg;
    input [7:0] a;
    input [7:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  reg [15:0] cmd_id_reg;
  reg [15:0] cmd_src_reg;
  reg [15:0] cmd_dst_reg;
  reg [31:0] cmd_pld_reg;
  reg        bcast_reg;
  reg        coinc_reg;
  reg        async_reg;
  reg [7:0]  retry_lim_reg;
  reg [15:0] wait_cfg_reg;
  reg [3:0]  state_reg;
  reg        launched_reg;
  reg        start_reg;
  reg [31:0] tx_reg;
  reg [7:0]  retry_cnt_reg;
  reg [15:0] wait_cnt_reg;
  reg        done_flag_reg;
  reg [15:0] resp_id_reg;
  reg [15:0] resp_src_reg;
  reg [15:0] resp_dst_reg;
  reg [31:0] resp_pld_reg;
  reg [31:0] rdata_next;
  reg        rerr_next;

  wire [31:0] sh_rx;
  wire        sh_done;
  wire        sh_busy;
  wire        go_wr;
  wire        bus_wr;
  wire [31:0] hdr_word;
  wire [31:0] echo_word;
  wire        dst_valid;
  wire        rx_cr;
  wire        rx_id_match;

  // big-endian assembly: id in the upper half, destination below
  assign hdr_word    = {cmd_id_reg[15] | async_reg, cmd_id_reg[14:0], cmd_dst_reg};
  assign echo_word   = hdr_word;
  assign dst_valid   = (cmd_dst_reg < `SCR_NUM_SLOTS);
  assign rx_cr       = sh_rx[16 + `SCR_CR_BIT];
  assign rx_id_match = (sh_rx[30:16] == cmd_id_reg[14:0]) && (sh_rx[15:0] == cmd_dst_reg);
  assign bus_wr      = psel & penable & pready & pwrite;
  assign go_wr       = bus_wr & is_reg(paddr, `SCR_OFF_CTRL) & pwdata[`SCR_CTRL_GO];

  scr_spi_shifter #(
    .HALF (HALF)
  ) u_shifter (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (start_reg),
    .tx      (tx_reg),
    .rx      (sh_rx),
    .busy    (sh_busy),
    .done    (sh_done),
    .sclk    (spi_sclk),
    .mosi    (spi_mosi),
    .miso    (spi_miso)
  );

  always @*
  begin
    rdata_next = 32'h0000_0000;
    rerr_next  = 1'b0;
    case (paddr)
      `SCR_OFF_CTRL:     rdata_next = {28'h0000000, async_reg, coinc_reg, bcast_reg, 1'b0};
      `SCR_OFF_CMD:      rdata_next = {cmd_src_reg, cmd_id_reg};
      `SCR_OFF_DST:      rdata_next = {16'h0000, cmd_dst_reg};
      `SCR_OFF_PAYLOAD:  rdata_next = cmd_pld_reg;
      `SCR_OFF_CFG:      rdata_next = {wait_cfg_reg, 8'h00, retry_lim_reg};
      `SCR_OFF_STATUS:   rdata_next = {16'h0000, retry_cnt_reg, 6'h00, done_flag_reg, relay_busy};
      `SCR_OFF_RESP_HDR: rdata_next = {resp_dst_reg, resp_id_reg};
      `SCR_OFF_RESP_SRC: rdata_next = {16'h0000, resp_src_reg};
      `SCR_OFF_RESP_PLD: rdata_next = resp_pld_reg;
      default:           rerr_next  = 1'b1;
    endcase
  end

  // one wait state so that read data and ready both leave flip-flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rerr_next;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  // command registers are locked while a relay is in flight
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_id_reg    <= 16'h0000;
      cmd_src_reg   <= 16'h0000;
      cmd_dst_reg   <= 16'h0000;
      cmd_pld_reg   <= 32'h0000_0000;
      bcast_reg     <= 1'b0;
      coinc_reg     <= 1'b0;
      async_reg     <= 1'b0;
      retry_lim_reg <= `SCR_CFG_RETRY_RST;
      wait_cfg_reg  <= `SCR_CFG_WAIT_RST;
    end
    else if (ce && bus_wr && !relay_busy)
    begin
      if (is_reg(paddr, `SCR_OFF_CTRL))
      begin
        bcast_reg <= pwdata[`SCR_CTRL_BCAST];
        coinc_reg <= pwdata[`SCR_CTRL_COINC];
        async_reg <= pwdata[`SCR_CTRL_ASYNC];
      end
      if (is_reg(paddr, `SCR_OFF_CMD))
      begin
        cmd_id_reg  <= pwdata[15:0];
        cmd_src_reg <= pwdata[31:16];
      end
      if (is_reg(paddr, `SCR_OFF_DST))
        cmd_dst_reg <= pwdata[15:0];
      if (is_reg(paddr, `SCR_OFF_PAYLOAD))
        cmd_pld_reg <= pwdata;
      if (is_reg(paddr, `SCR_OFF_CFG))
      begin
        retry_lim_reg <= pwdata[7:0];
        wait_cfg_reg  <= pwdata[31:16];
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= ST_IDLE;
      launched_reg  <= 1'b0;
      start_reg     <= 1'b0;
      tx_reg        <= 32'h0000_0000;
      spi_ss_n      <= `SCR_SS_IDLE;
      relay_busy    <= 1'b0;
      retry_cnt_reg <= 8'h00;
      wait_cnt_reg  <= 16'h0000;
      done_flag_reg <= 1'b0;
      resp_id_reg   <= 16'h0000;
      resp_src_reg  <= 16'h0000;
      resp_dst_reg  <= 16'h0000;
      resp_pld_reg  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (go_wr && !relay_busy)
          begin
            relay_busy    <= 1'b1;
            done_flag_reg <= 1'b0;
            retry_cnt_reg <= 8'h00;
            resp_dst_reg  <= cmd_src_reg;
            // flags ride in the same write as go, the flag registers are not updated yet
            if (pwdata[`SCR_CTRL_BCAST])
              state_reg <= ST_WR_HDR;
            else if (pwdata[`SCR_CTRL_COINC] || cmd_dst_reg == OWN_ADDR)
              state_reg <= ST_LOCAL;
            else if (!dst_valid)
            begin
              resp_id_reg  <= `SCR_DEAD_CODE;
              resp_src_reg <= OWN_ADDR;
              resp_pld_reg <= cmd_pld_reg;
              state_reg    <= ST_WAIT;
              wait_cnt_reg <= 16'h0000;
              done_flag_reg <= 1'b1;
              relay_busy   <= 1'b0;
            end
            else
              state_reg <= ST_WR_HDR;
          end
        end
        ST_LOCAL:
        begin
          resp_src_reg <= OWN_ADDR;
          resp_pld_reg <= cmd_pld_reg;
          if (cmd_id_reg[14:0] == `SCR_CMD_PING)
            resp_id_reg <= cmd_id_reg | 16'h8000;
          else
            resp_id_reg <= `SCR_UNKNOWN_CODE;
          done_flag_reg <= 1'b1;
          relay_busy    <= 1'b0;
          state_reg     <= ST_IDLE;
        end
        ST_WR_HDR, ST_WR_PLD, ST_WR_ECHO, ST_POLL, ST_POLL_PLD:
        begin
          if (!launched_reg && !sh_busy)
          begin
            launched_reg <= 1'b1;
            start_reg    <= 1'b1;
            // broadcast writes hit every slot, readbacks only the destination
            if (bcast_reg && (state_reg == ST_WR_HDR || state_reg == ST_WR_PLD))
              spi_ss_n <= 10'h000;
            else
              spi_ss_n <= slot_sel_n(cmd_dst_reg);
            if (state_reg == ST_WR_HDR)
              tx_reg <= hdr_word;
            else if (state_reg == ST_WR_PLD)
              tx_reg <= cmd_pld_reg;
            else
              tx_reg <= 32'h0000_0000;
          end
          else if (sh_done)
          begin
            launched_reg <= 1'b0;
            spi_ss_n     <= `SCR_SS_IDLE;
            case (state_reg)
              ST_WR_HDR: state_reg <= ST_WR_PLD;
              ST_WR_PLD:
              begin
                if (coinc_reg || (bcast_reg && (cmd_dst_reg == OWN_ADDR || !dst_valid)))
                  state_reg <= ST_LOCAL;
                else
                  state_reg <= ST_WR_ECHO;
              end
              ST_WR_ECHO:
              begin
                resp_src_reg <= cmd_dst_reg;
                resp_pld_reg <= cmd_pld_reg;
                if (sh_rx == 32'hffff_ffff)
                begin
                  resp_id_reg   <= `SCR_DEAD_CODE;
                  done_flag_reg <= 1'b1;
                  relay_busy    <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
                else if (sh_rx != echo_word)
                begin
                  resp_id_reg   <= `SCR_BUSY_CODE;
                  done_flag_reg <= 1'b1;
                  relay_busy    <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
                else if (async_reg)
                begin
                  resp_id_reg   <= cmd_id_reg | 16'h8000;
                  done_flag_reg <= 1'b1;
                  relay_busy    <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
                else
                  state_reg <= ST_POLL;
              end
              ST_POLL:
              begin
                if (sh_rx[31:16] == `SCR_TIMEOUT_CODE || sh_rx[31:16] == `SCR_UNKNOWN_CODE)
                begin
                  resp_id_reg   <= sh_rx[31:16];
                  done_flag_reg <= 1'b1;
                  relay_busy    <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
                else if (rx_cr && rx_id_match)
                begin
                  resp_id_reg <= sh_rx[31:16];
                  state_reg   <= ST_POLL_PLD;
                end
                else if (retry_cnt_reg + 8'h01 >= retry_lim_reg)
                begin
                  retry_cnt_reg <= retry_cnt_reg + 8'h01;
                  resp_id_reg   <= `SCR_TIMEOUT_CODE;
                  done_flag_reg <= 1'b1;
                  relay_busy    <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
                else
                begin
                  retry_cnt_reg <= retry_cnt_reg + 8'h01;
                  wait_cnt_reg  <= wait_cfg_reg;
                  state_reg     <= ST_WAIT;
                end
              end
              default:
              begin
                resp_pld_reg  <= sh_rx;
                done_flag_reg <= 1'b1;
                relay_busy    <= 1'b0;
                state_reg     <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WAIT:
        begin
          if (!relay_busy)
            state_reg <= ST_IDLE;
          else if (wait_cnt_reg == 16'h0000)
            state_reg <= ST_POLL;
          else
            wait_cnt_reg <= wait_cnt_reg - 16'h0001;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // scr_relay

/* File: verification/scr_checker.sv */
// assertions on the relay's apb and serial ports
`timescale 1ns/1ns
module scr_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        spi_sclk,
  input wire logic        spi_mosi,
  input wire logic [9:0]  spi_ss_n,
  input wire logic        relay_busy
);
  logic [5:0] edges_reg;
  logic       sclk_reg;
  // rising serial edges since the select went low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      edges_reg <= 6'h00;
      sclk_reg  <= 1'b0;
    end
    else
    begin
      sclk_reg  <= spi_sclk;
      edges_reg <= (&spi_ss_n) ? 6'h00 : edges_reg + {5'h00, spi_sclk & ~sclk_reg};
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb wait state count wrong");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a transfer");
  property p_sel_shape;
    $onehot0(~spi_ss_n) || spi_ss_n == 10'h000;
  endproperty
  a_sel_shape: assert property (p_sel_shape) else $error("bad child select pattern");
  property p_sclk_idle;
    &spi_ss_n |-> !spi_sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs while deselected");
  property p_busy_sel;
    !(&spi_ss_n) |-> relay_busy;
  endproperty
  a_busy_sel: assert property (p_busy_sel) else $error("select active while relay idle");
  property p_mosi_hold;
    spi_sclk |-> $stable(spi_mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
  property p_word_bits;
    $rose(&spi_ss_n) |-> edges_reg == 6'd32;
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("serial word not 32 bits");
endmodule // scr_checker

bind scr_relay scr_checker scr_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
  .spi_ss_n(spi_ss_n), .relay_busy(relay_busy));

/* File: verification/scr_child_model.sv */
// behavioural child boards behind the ten serial selects
`timescale 1ns/1ns
`include "scr_defines.vh"
module scr_child_model (
  input  wire logic       pclk,
  input  wire logic [9:0] spi_ss_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  output wire logic       spi_miso,
  input  wire logic [9:0] absent,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] polls
);
  logic [31:0] hdr [10];
  logic [31:0] pld [10];
  logic [2:0]  ph [10];
  logic [31:0] sh;
  logic [31:0] rx;
  logic [3:0]  left;
  logic [9:0]  ss_reg = 10'h3ff;
  logic        sclk_reg = 1'b0;
  logic        drv = 1'b0;
  // released or empty slot floats to the pull-up level
  assign spi_miso = drv ? sh[31] : 1'b1;
  initial
    for (int i = 0; i < 10; i++)
      ph[i] = 3'd0;
  // mode 1 busy, 2 unknown code, 3 never answers
  function automatic logic [2:0] ph_next(input logic [2:0] p, input logic wr, input logic hold);
    if (wr)
      return (p == 3'd1) ? 3'd2 : 3'd1;
    case (p)
      3'd2: return (mode == 2'd1) ? 3'd0 : 3'd3;
      3'd3: return (hold || mode == 2'd3) ? 3'd3 : (mode == 2'd2) ? 3'd0 : 3'd4;
      3'd4: return 3'd0;
      default: return p;
    endcase
  endfunction
  always @(posedge pclk)
  begin
    sclk_reg <= spi_sclk;
    ss_reg   <= spi_ss_n;
    if (spi_sclk && !sclk_reg)
      rx <= {rx[30:0], spi_mosi};
    if (!spi_sclk && sclk_reg)
      sh <= {sh[30:0], 1'b0};
    if (&ss_reg && !(&spi_ss_n))
      for (int i = 0; i < 10; i++)
        if (!spi_ss_n[i] && $onehot(~spi_ss_n) && !absent[i])
        begin
          drv <= 1'b1;
          case (ph[i])
            3'd2: sh <= (mode == 2'd1) ? hdr[i] ^ 32'h1 : hdr[i];
            3'd3: sh <= (left != 0 || mode == 2'd3) ? hdr[i] :
                        (mode == 2'd2) ? {`SCR_UNKNOWN_CODE, hdr[i][15:0]} : hdr[i] | 32'h80000000;
            3'd4: sh <= pld[i];
            default: sh <= 32'h0;
          endcase
        end
    if (!(&ss_reg) && &spi_ss_n)
    begin
      drv <= 1'b0;
      for (int i = 0; i < 10; i++)
        if (!ss_reg[i] && !absent[i])
        begin
          if (rx != 32'h0 && ph[i] != 3'd1)
            hdr[i] <= rx;
          if (rx != 32'h0 && ph[i] == 3'd1)
            pld[i] <= rx;
          if (rx != 32'h0)
            left <= polls;
          else if (ph[i] == 3'd3 && left != 0)
            left <= left - 4'd1;
          ph[i] <= ph_next(ph[i], rx != 32'h0, left != 0);
        end
    end
  end
endmodule // scr_child_model

/* File: verification/spi_command_relay_tb_top.sv */
// self-checking bench for the serial command relay
`timescale 1ns/1ns
`include "scr_defines.vh"
module spi_command_relay_tb_top;
  typedef struct { string nm; logic [32:0] ex; logic [32:0] mk; } scr_note_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        spi_sclk, spi_mosi, spi_miso, relay_busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, src, pd;
  logic [9:0]  spi_ss_n, absent;
  logic [1:0]  mode;
  logic [3:0]  polls;
  integer      seed, err_count, comparisons;
  scr_note_t   notes [$];
  scr_note_t   nt;
  logic [15:0] dst_t [4] = '{16'h5, 16'h2, 16'h1, 16'h8};
  logic [15:0] code_t [4] = '{`SCR_DEAD_CODE, `SCR_BUSY_CODE, `SCR_UNKNOWN_CODE, `SCR_TIMEOUT_CODE};
  scr_relay scr_relay_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_ss_n(spi_ss_n), .relay_busy(relay_busy));
  scr_child_model scr_child_model_i (.pclk(pclk), .spi_ss_n(spi_ss_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .absent(absent), .mode(mode), .polls(polls));
  always #20 pclk = ~pclk;
  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    comparisons++;
    if (seen !== ex)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic hang();
    err_count++;
    summarize();
  endtask
  // results land at the edge that samples pready
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt.mk != 33'h0)
        check(nt.nm, {pslverr, prdata} & nt.mk, nt.ex);
    end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 40)
      hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [32:0] mk, input string nm);
    notes.push_back('{nm, ex, mk});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic go(input logic [15:0] id, input logic [15:0] dst, input logic [3:0] fl);
    int n;
    src = 32'h0000_4000;
    pd = $random(seed) | 32'h1;
    apb(1'b1, `SCR_OFF_CMD, {src[15:0], id});
    apb(1'b1, `SCR_OFF_DST, {16'h0, dst});
    apb(1'b1, `SCR_OFF_PAYLOAD, pd);
    apb(1'b1, `SCR_OFF_CTRL, {28'h0, fl | 4'h1});
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    n = 0;
    do
    begin
      rd(`SCR_OFF_STATUS, 33'h0, 33'h0, "status");
      n++;
    end
    while (rdv[1] !== 1'b1 && n < 4000);
    if (n >= 4000)
      hang();
    check("relay busy", {32'h0, relay_busy}, 33'h0);
  endtask
  task automatic reply(input string nm, input logic [15:0] rid, input logic [15:0] rsrc, input logic full);
    rd(`SCR_OFF_RESP_HDR, {1'b0, src[15:0], rid}, 33'h0ffffffff, nm);
    if (full)
    begin
      rd(`SCR_OFF_RESP_SRC, {17'h0, rsrc}, 33'h00000ffff, nm);
      rd(`SCR_OFF_RESP_PLD, {1'b0, pd}, 33'h0ffffffff, nm);
    end
  endtask
  initial
  begin
    seed = 32'h895d;
    err_count = 0;
    comparisons = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    absent = 10'h020;
    mode = 2'd0;
    polls = 4'h2;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SCR_OFF_CFG, {17'h0100, 8'h00, 8'h08}, 33'h1ffffffff, "cfg reset");
    rd(8'h40, 33'h100000000, 33'h1ffffffff, "unmapped");
    apb(1'b1, `SCR_OFF_CFG, 32'h0010_0003);
    go(16'h0001, 16'h0003, 4'h0);
    reply("ping", 16'h8001, 16'h0003, 1'b1);
    check("header word", {1'b0, scr_child_model_i.hdr[3]}, {17'h0001, 16'h0003});
    check("payload word", {1'b0, scr_child_model_i.pld[3]}, {1'b0, pd});
    polls <= 4'h1;
    for (int k = 0; k < 4; k++)
    begin
      mode <= k[1:0];
      go(16'h0002, dst_t[k], 4'h0);
      reply("fault", code_t[k], 16'h0, 1'b0);
    end
    mode <= 2'd0;
    go(16'h0001, `SCR_OWN_ADDR_RST, 4'h0);
    reply("local", 16'h8001, `SCR_OWN_ADDR_RST, 1'b1);
    go(16'h0033, `SCR_OWN_ADDR_RST, 4'h0);
    reply("local unknown", `SCR_UNKNOWN_CODE, 16'h0, 1'b0);
    go(16'h0001, 16'h0004, 4'h4);
    reply("coinc", 16'h8001, `SCR_OWN_ADDR_RST, 1'b1);
    go(16'h0001, 16'h0007, 4'h2);
    reply("broadcast", 16'h8001, 16'h0007, 1'b1);
    check("bcast slot0", {1'b0, scr_child_model_i.hdr[0]}, {17'h0001, 16'h0007});
    check("bcast slot9", {1'b0, scr_child_model_i.hdr[9]}, {17'h0001, 16'h0007});
    go(16'h0001, 16'h0007, 4'h6);
    reply("bcast coinc", 16'h8001, `SCR_OWN_ADDR_RST, 1'b1);
    go(16'h0001, 16'h0006, 4'h8);
    reply("async", 16'h8001, 16'h0006, 1'b0);
    check("async header", {1'b0, scr_child_model_i.hdr[6]}, {17'h8001, 16'h0006});
    summarize();
  end
endmodule // spi_command_relay_tb_top
